// File: pkg/bca_defs.svh
`ifndef BCA_DEFS_SVH
`define BCA_DEFS_SVH

`define BCA_CYC_ILLEGAL   3'h0
`define BCA_CYC_ONE       3'h1
`define BCA_CYC_ALU_MEM   3'h2
`define BCA_CYC_RMW       3'h3
`define BCA_CYC_INC_REG   3'h2
`define BCA_CYC_MUL       3'h2
`define BCA_CYC_DIV       3'h6
`define BCA_CYC_DA        3'h3
`define BCA_CYC_CODE_RD   3'h5
`define BCA_CYC_WIDE_RD   3'h3
`define BCA_CYC_LD_MUL    3'h2
`define BCA_CYC_LD_PTR    3'h3
`define BCA_CYC_BIT       3'h2

`define BCA_CNT_LAST      3'h1
`define BCA_CNT_WRITE     3'h2

`define BCA_RST_BYTE      8'h00
`define BCA_RST_WORD      16'h0000
`define BCA_PAGE_ZERO     8'h00
`define BCA_BIT_RAM_BASE  8'h20
`define BCA_BIT_SFR_MSB   7
`define BCA_NIB_LIMIT     4'h9
`define BCA_DA_LO_ADJ     9'h006
`define BCA_DA_HI_ADJ     9'h060

`endif

// File: pkg/bca_pkg.sv
`default_nettype none
package bca_pkg;

  typedef enum logic [4:0] {
    add_op, add_with_carry_op, subtract_with_borrow_op, increment_op, decrement_op,
    inc_pointer_op, multiply_op, divide_op, decimal_adjust_op,
    logical_and_op, logical_or_op, logical_xor_op, clear_acc_op, complement_acc_op,
    rotate_left_op, rotate_left_carry_op, rotate_right_op, rotate_right_carry_op,
    swap_nibbles_op, code_read_op, load_acc_op, store_reg_op, load_mul_operand_op,
    load_pointer_op, bit_to_carry_op
  } bca_op_e;

  typedef enum logic [2:0] {
    mode_acc, mode_reg, mode_direct, mode_indirect, mode_immediate,
    mode_direct_acc, mode_direct_imm, mode_indirect_wide
  } bca_mode_e;

  typedef enum logic [1:0] {
    st_idle  = 2'h0,
    st_read  = 2'h1,
    st_wait  = 2'h3,
    st_write = 2'h2
  } bca_state_e;

endpackage : bca_pkg
`default_nettype wire

// File: design/bca_timing.sv
`include "bca_defs.svh"
`default_nettype none
module bca_timing (
  // instruction
  input  wire bca_pkg::bca_op_e   op,
  input  wire bca_pkg::bca_mode_e mode,
  // decode
  output logic [2:0]              cycles,
  output logic                    rd_mem,
  output logic                    rd_code,
  output logic                    mem_dest
);
  import bca_pkg::*;

  logic mem_src;

  assign mem_src = (mode == mode_direct) || (mode == mode_indirect);

  always_comb begin
    cycles   = `BCA_CYC_ILLEGAL;
    rd_mem   = 1'b0;
    rd_code  = 1'b0;
    mem_dest = 1'b0;
    case (op)
      add_op, add_with_carry_op, subtract_with_borrow_op,
      logical_and_op, logical_or_op, logical_xor_op, load_acc_op: begin
        rd_mem = mem_src;
        if (mode == mode_reg) begin
          cycles = `BCA_CYC_ONE;
        end else if (mem_src || mode == mode_immediate) begin
          cycles = `BCA_CYC_ALU_MEM;
        end else if ((mode == mode_direct_acc || mode == mode_direct_imm) &&
                     (op == logical_and_op || op == logical_or_op ||
                      op == logical_xor_op)) begin
          cycles   = `BCA_CYC_RMW;
          rd_mem   = 1'b1;
          mem_dest = 1'b1;
        end else if (mode == mode_indirect_wide && op == load_acc_op) begin
          cycles = `BCA_CYC_WIDE_RD;
          rd_mem = 1'b1;
        end
      end
      increment_op, decrement_op: begin
        if (mode == mode_acc) begin
          cycles = `BCA_CYC_ONE;
        end else if (mode == mode_reg) begin
          cycles = `BCA_CYC_INC_REG;
        end else if (mem_src) begin
          cycles   = `BCA_CYC_RMW;
          rd_mem   = 1'b1;
          mem_dest = 1'b1;
        end
      end
      inc_pointer_op:      cycles = `BCA_CYC_ONE;
      multiply_op:         cycles = `BCA_CYC_MUL;
      divide_op:           cycles = `BCA_CYC_DIV;
      decimal_adjust_op:   cycles = `BCA_CYC_DA;
      clear_acc_op, complement_acc_op, swap_nibbles_op,
      rotate_left_op, rotate_left_carry_op,
      rotate_right_op, rotate_right_carry_op: cycles = `BCA_CYC_ONE;
      code_read_op: begin
        cycles  = `BCA_CYC_CODE_RD;
        rd_code = 1'b1;
      end
      store_reg_op:        cycles = `BCA_CYC_ONE;
      load_mul_operand_op: cycles = `BCA_CYC_LD_MUL;
      load_pointer_op:     cycles = `BCA_CYC_LD_PTR;
      bit_to_carry_op: begin
        cycles = `BCA_CYC_BIT;
        rd_mem = 1'b1;
      end
      default:             cycles = `BCA_CYC_ILLEGAL;
    endcase
  end

endmodule : bca_timing
`default_nettype wire

// File: design/bca_alu.sv
`include "bca_defs.svh"
`default_nettype none
module bca_alu (
  // operands
  input  wire bca_pkg::bca_op_e op,
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       s,
  input  wire logic [7:0]       bop,
  // flags in
  input  wire logic             cy_i,
  input  wire logic             ac_i,
  input  wire logic             ov_i,
  // results
  output logic [7:0]            res,
  output logic [7:0]            res_hi,
  output logic                  cy_o,
  output logic                  ac_o,
  output logic                  ov_o
);
  import bca_pkg::*;

  logic [8:0]  sum;
  logic [4:0]  lo;
  logic [15:0] prod;
  logic        cin;

  always_comb begin
    res    = a;
    res_hi = bop;
    cy_o   = cy_i;
    ac_o   = ac_i;
    ov_o   = ov_i;
    cin    = (op == add_with_carry_op) ? cy_i : 1'b0;
    sum    = {1'b0, a};
    lo     = 5'h00;
    prod   = {8'h00, a} * {8'h00, bop};
    case (op)
      add_op, add_with_carry_op: begin
        sum  = {1'b0, a} + {1'b0, s} + {8'h00, cin};
        lo   = {1'b0, a[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
        res  = sum[7:0];
        cy_o = sum[8];
        ac_o = lo[4];
        ov_o = (a[7] == s[7]) && (sum[7] != a[7]);
      end
      subtract_with_borrow_op: begin
        sum  = {1'b0, a} - {1'b0, s} - {8'h00, cy_i};
        lo   = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, cy_i};
        res  = sum[7:0];
        cy_o = sum[8];
        ac_o = lo[4];
        ov_o = (a[7] != s[7]) && (sum[7] != a[7]);
      end
      increment_op:      res = a + 8'h01;
      decrement_op:      res = a - 8'h01;
      multiply_op: begin
        res    = prod[7:0];
        res_hi = prod[15:8];
        cy_o   = 1'b0;
        ov_o   = |prod[15:8];
      end
      divide_op: begin
        cy_o = 1'b0;
        if (bop == `BCA_RST_BYTE) begin
          // divide by zero keeps operands, sets overflow
          ov_o = 1'b1;
        end else begin
          res    = a / bop;
          res_hi = a % bop;
          ov_o   = 1'b0;
        end
      end
      decimal_adjust_op: begin
        sum = {1'b0, a};
        if (a[3:0] > `BCA_NIB_LIMIT || ac_i) begin
          sum = sum + `BCA_DA_LO_ADJ;
        end
        if (sum[7:4] > `BCA_NIB_LIMIT || sum[8] || cy_i) begin
          sum = sum + `BCA_DA_HI_ADJ;
        end
        res  = sum[7:0];
        cy_o = cy_i | sum[8];
      end
      logical_and_op:       res = a & s;
      logical_or_op:        res = a | s;
      logical_xor_op:       res = a ^ s;
      clear_acc_op:         res = `BCA_RST_BYTE;
      complement_acc_op:    res = ~a;
      rotate_left_op:       res = {a[6:0], a[7]};
      rotate_right_op:      res = {a[0], a[7:1]};
      rotate_left_carry_op: begin
        res  = {a[6:0], cy_i};
        cy_o = a[7];
      end
      rotate_right_carry_op: begin
        res  = {cy_i, a[7:1]};
        cy_o = a[0];
      end
      swap_nibbles_op:      res = {a[3:0], a[7:4]};
      code_read_op, load_acc_op: res = s;
      default:              res = a;
    endcase
  end

endmodule : bca_alu
`default_nettype wire

// File: design/bca_core.sv
`include "bca_defs.svh"
`default_nettype none
module bca_core #(
  parameter int NUM_BANKS     = 4,
  parameter int REGS_PER_BANK = 8
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // instruction request
  input  wire logic               instr_valid,
  input  wire bca_pkg::bca_op_e   instr_op,
  input  wire bca_pkg::bca_mode_e instr_mode,
  input  wire logic [2:0]         instr_reg,
  input  wire logic [7:0]         instr_addr,
  input  wire logic [7:0]         instr_imm,
  input  wire logic [1:0]         bank_sel,
  // instruction status
  output logic                    instr_ready,
  output logic                    instr_done,
  output logic                    instr_error,
  // data memory port
  output logic [15:0]             mem_addr,
  output logic                    mem_wide,
  output logic                    mem_rd,
  output logic                    mem_wr,
  output logic [7:0]              mem_wdata,
  input  wire logic [7:0]         mem_rdata,
  // program memory port
  output logic [15:0]             code_addr,
  output logic                    code_rd,
  input  wire logic [7:0]         code_rdata,
  // architectural state
  output logic [7:0]              acc,
  output logic [7:0]              mul_operand,
  output logic [15:0]             wide_data_pointer,
  output logic                    carry,
  output logic                    aux_carry,
  output logic                    overflow
);
  import bca_pkg::*;

  localparam int NUM_REGS = NUM_BANKS * REGS_PER_BANK;

  logic [7:0]  bank_working_register [0:NUM_REGS-1];
  bca_state_e  state;
  logic [2:0]  cnt;
  bca_op_e     op_q;
  bca_mode_e   mode_q;
  logic [4:0]  ridx_q;
  logic [7:0]  addr_q;
  logic [7:0]  imm_q;
  logic        mem_dest_q;
  logic [7:0]  opnd;

  logic [2:0]  cycles;
  logic        dec_rd_mem, dec_rd_code, dec_mem_dest, accept, exec_now, exec_late, exec, busy;
  bca_op_e     cur_op;
  bca_mode_e   cur_mode;
  logic [4:0]  cur_ridx;
  logic [7:0]  cur_imm;
  logic [4:0]  new_ridx;
  logic [4:0]  ptr_ridx;
  logic [7:0]  reg_val;
  logic [7:0]  live_opnd;
  logic [7:0]  alu_a;
  logic [7:0]  alu_s;
  logic [7:0]  alu_res;
  logic [7:0]  alu_res_hi;
  logic        alu_cy, alu_ac, alu_ov, acc_dest, reg_dest;
  logic [7:0]  bit_byte;
  logic [15:0] next_mem_addr;

  bca_timing u_timing (
    .op       (instr_op),
    .mode     (instr_mode),
    .cycles   (cycles),
    .rd_mem   (dec_rd_mem),
    .rd_code  (dec_rd_code),
    .mem_dest (dec_mem_dest)
  );

  assign busy      = (state != st_idle);
  assign accept    = instr_valid && instr_ready;
  assign exec_now  = accept && (cycles == `BCA_CYC_ONE);
  // memory destinations compute early so the write fits the count
  assign exec_late = busy && (cnt == (mem_dest_q ? `BCA_CNT_WRITE : `BCA_CNT_LAST));
  assign exec      = exec_now || exec_late;

  assign new_ridx  = {bank_sel, instr_reg};
  assign ptr_ridx  = {bank_sel, 2'h0, instr_reg[0]};
  assign cur_op    = exec_now ? instr_op : op_q;
  assign cur_mode  = exec_now ? instr_mode : mode_q;
  assign cur_ridx  = exec_now ? new_ridx : ridx_q;
  assign cur_imm   = exec_now ? instr_imm : imm_q;
  assign reg_val   = bank_working_register[cur_ridx];

  // read data stands only with its strobe; later cycles use the latch
  assign live_opnd = code_rd ? code_rdata : (mem_rd ? mem_rdata : opnd);

  always_comb begin
    case (cur_mode)
      mode_reg:        alu_s = reg_val;
      mode_immediate:  alu_s = cur_imm;
      mode_direct_acc: alu_s = acc;
      mode_direct_imm: alu_s = cur_imm;
      default:         alu_s = live_opnd;
    endcase
    if (cur_op == increment_op || cur_op == decrement_op) begin
      case (cur_mode)
        mode_acc: alu_a = acc;
        mode_reg: alu_a = reg_val;
        default:  alu_a = live_opnd;
      endcase
    end else if (cur_mode == mode_direct_acc || cur_mode == mode_direct_imm) begin
      alu_a = live_opnd;
    end else begin
      alu_a = acc;
    end
  end

  always_comb begin
    case (cur_op)
      increment_op, decrement_op: begin
        acc_dest = (cur_mode == mode_acc);
        reg_dest = (cur_mode == mode_reg);
      end
      logical_and_op, logical_or_op, logical_xor_op: begin
        acc_dest = (cur_mode != mode_direct_acc) && (cur_mode != mode_direct_imm);
        reg_dest = 1'b0;
      end
      inc_pointer_op, load_pointer_op, load_mul_operand_op, bit_to_carry_op: begin
        acc_dest = 1'b0;
        reg_dest = 1'b0;
      end
      store_reg_op: begin
        acc_dest = 1'b0;
        reg_dest = 1'b1;
      end
      default: begin
        acc_dest = 1'b1;
        reg_dest = 1'b0;
      end
    endcase
  end

  bca_alu u_alu (
    .op     (cur_op),
    .a      (alu_a),
    .s      (alu_s),
    .bop    (mul_operand),
    .cy_i   (carry),
    .ac_i   (aux_carry),
    .ov_i   (overflow),
    .res    (alu_res),
    .res_hi (alu_res_hi),
    .cy_o   (alu_cy),
    .ac_o   (alu_ac),
    .ov_o   (alu_ov)
  );

  // low bit half in a RAM block, upper half in register bytes
  assign bit_byte = instr_addr[`BCA_BIT_SFR_MSB] ?
                    {instr_addr[7:3], 3'h0} :
                    (`BCA_BIT_RAM_BASE + {4'h0, instr_addr[6:3]});

  always_comb begin
    case (instr_mode)
      mode_indirect:      next_mem_addr = {`BCA_PAGE_ZERO, bank_working_register[ptr_ridx]};
      mode_indirect_wide: next_mem_addr = wide_data_pointer;
      default:            next_mem_addr = {`BCA_PAGE_ZERO, instr_addr};
    endcase
    if (instr_op == bit_to_carry_op) begin
      next_mem_addr = {`BCA_PAGE_ZERO, bit_byte};
    end
  end

  // sequencing and completion timing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= st_idle;
      cnt         <= `BCA_CYC_ILLEGAL;
      instr_ready <= 1'b1;
      instr_done  <= 1'b0;
      instr_error <= 1'b0;
    end else begin
      instr_done  <= exec_now || (busy && cnt == `BCA_CNT_LAST);
      instr_error <= accept && (cycles == `BCA_CYC_ILLEGAL);
      if (accept && cycles > `BCA_CYC_ONE) begin
        cnt         <= cycles - `BCA_CYC_ONE;
        instr_ready <= 1'b0;
        state       <= (dec_rd_mem || dec_rd_code) ? st_read : st_wait;
      end else if (busy) begin
        cnt <= cnt - `BCA_CNT_LAST;
        if (cnt == `BCA_CNT_LAST) begin
          state       <= st_idle;
          instr_ready <= 1'b1;
        end else if (mem_dest_q && cnt == `BCA_CNT_WRITE) begin
          state <= st_write;
        end else begin
          state <= st_wait;
        end
      end
    end
  end

  // instruction capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q       <= add_op;
      mode_q     <= mode_acc;
      ridx_q     <= 5'h00;
      addr_q     <= `BCA_RST_BYTE;
      imm_q      <= `BCA_RST_BYTE;
      mem_dest_q <= 1'b0;
      opnd       <= `BCA_RST_BYTE;
    end else begin
      if (accept) begin
        op_q       <= instr_op;
        mode_q     <= instr_mode;
        ridx_q     <= new_ridx;
        addr_q     <= instr_addr;
        imm_q      <= instr_imm;
        mem_dest_q <= dec_mem_dest;
      end
      if (mem_rd || code_rd) begin
        opnd <= live_opnd;
      end
    end
  end

  // memory and program memory ports
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr  <= `BCA_RST_WORD;
      mem_wide  <= 1'b0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= `BCA_RST_BYTE;
      code_addr <= `BCA_RST_WORD;
      code_rd   <= 1'b0;
    end else begin
      mem_rd  <= accept && dec_rd_mem;
      code_rd <= accept && dec_rd_code;
      mem_wr  <= exec_late && mem_dest_q;
      if (accept && dec_rd_mem) begin
        mem_addr <= next_mem_addr;
        mem_wide <= (instr_mode == mode_indirect_wide) && (instr_op != bit_to_carry_op);
      end
      if (accept && dec_rd_code) begin
        code_addr <= wide_data_pointer + {`BCA_PAGE_ZERO, acc};
      end
      if (exec_late && mem_dest_q) begin
        mem_wdata <= alu_res;
      end
    end
  end

  // accumulator, operand register, pointer and flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc               <= `BCA_RST_BYTE;
      mul_operand       <= `BCA_RST_BYTE;
      wide_data_pointer <= `BCA_RST_WORD;
      carry             <= 1'b0;
      aux_carry         <= 1'b0;
      overflow          <= 1'b0;
    end else if (exec) begin
      if (acc_dest) begin
        acc <= alu_res;
      end
      if (cur_op == multiply_op || cur_op == divide_op) begin
        mul_operand <= alu_res_hi;
      end else if (cur_op == load_mul_operand_op) begin
        mul_operand <= acc;
      end
      if (cur_op == inc_pointer_op) begin
        wide_data_pointer <= wide_data_pointer + 16'h0001;
      end else if (cur_op == load_pointer_op) begin
        wide_data_pointer <= {addr_q, imm_q};
      end
      carry     <= (cur_op == bit_to_carry_op) ? live_opnd[addr_q[2:0]] : alu_cy;
      aux_carry <= alu_ac;
      overflow  <= alu_ov;
    end
  end

  // working registers, kept local so a register source costs no memory cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        bank_working_register[i] <= `BCA_RST_BYTE;
      end
    end else if (exec && reg_dest) begin
      bank_working_register[cur_ridx] <= (cur_op == store_reg_op) ? acc : alu_res;
    end
  end

endmodule : bca_core
`default_nettype wire

// File: verif/bca_core_monitor.sv
`default_nettype none
module bca_core_monitor (
  // clock and reset
  input wire logic                clk,
  input wire logic                arst_n,
  // request
  input wire logic                instr_valid,
  input wire bca_pkg::bca_op_e    instr_op,
  input wire bca_pkg::bca_mode_e  instr_mode,
  input wire logic [7:0]          instr_addr,
  input wire logic [7:0]          instr_imm,
  // status and ports
  input wire logic                instr_ready,
  input wire logic                instr_done,
  input wire logic [15:0]         mem_addr,
  input wire logic                mem_rd,
  input wire logic                mem_wr,
  input wire logic [15:0]         code_addr,
  input wire logic                code_rd,
  input wire logic [7:0]          acc,
  input wire logic [15:0]         wide_data_pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  import bca_pkg::*;
  logic go;
  assign go = instr_valid && instr_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_read;
    mem_rd && !instr_ready && !instr_done;
  endsequence
  sequence s_finish;
    instr_done && instr_ready;
  endsequence
  property p_reg_one;
    go && instr_mode == mode_reg && instr_op inside {add_op, add_with_carry_op} |=> s_finish;
  endproperty
  a_reg_one: assert property (p_reg_one)
    else $error("reg add timing");
  property p_direct_two;
    go && instr_mode == mode_direct && instr_op == subtract_with_borrow_op
      |=> (s_read and mem_addr == {8'h00, $past(instr_addr)}) ##1 s_finish;
  endproperty
  a_direct_two: assert property (p_direct_two)
    else $error("direct subtract_with_borrow_op");
  property p_mul;
    go && instr_op == multiply_op |=> !instr_done && !instr_ready ##1 s_finish;
  endproperty
  a_mul: assert property (p_mul)
    else $error("mul timing");
  property p_div;
    go && instr_op == divide_op |=> (!instr_done && !instr_ready)[*5] ##1 s_finish;
  endproperty
  a_div: assert property (p_div)
    else $error("div timing");
  property p_rmw;
    go && instr_op inside {logical_and_op, logical_or_op, logical_xor_op}
      && instr_mode inside {mode_direct_acc, mode_direct_imm}
      |=> s_read ##1 (mem_wr && $stable(mem_addr)) ##1 s_finish;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("logic rmw");
  property p_rotate;
    go && instr_op == rotate_left_op |=> instr_done && acc == $past({acc[6:0], acc[7]});
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate left");
  property p_swap;
    go && instr_op == swap_nibbles_op |=> instr_done && acc == $past({acc[3:0], acc[7:4]});
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap");
  property p_xor_imm;
    go && instr_op == logical_xor_op && instr_mode == mode_immediate
      |=> ##1 instr_done && acc == ($past(acc, 2) ^ $past(instr_imm, 2));
  endproperty
  a_xor_imm: assert property (p_xor_imm)
    else $error("xor imm");
  property p_code;
    go && instr_op == code_read_op
      |=> code_rd && code_addr == $past(wide_data_pointer) + {8'h00, $past(acc)} ##4 instr_done;
  endproperty
  a_code: assert property (p_code)
    else $error("code read");
  property p_inc_ptr;
    go && instr_op == inc_pointer_op
      |=> instr_done && wide_data_pointer == $past(wide_data_pointer) + 16'h0001;
  endproperty
  a_inc_ptr: assert property (p_inc_ptr)
    else $error("ptr inc");
endmodule : bca_core_monitor

bind bca_core bca_core_monitor i_bca_core_monitor (.*);
`default_nettype wire

// File: verif/bca_mem_model.sv
`default_nettype none
module bca_mem_model (
  // clock
  input wire logic        clk,
  // data memory
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  output logic [7:0]      mem_rdata,
  // program memory
  input wire logic [15:0] code_addr,
  input wire logic        code_rd,
  output logic [7:0]      code_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [256];
  logic [7:0] junk;
  initial begin
    junk = 8'hA5;
    for (int i = 0; i < 256; i++) ram[i] = 8'(i * 37 + 11);
  end
  // unselected reads show a moving pattern to expose late samples
  always @(posedge clk) begin
    junk <= ~junk + 8'h13;
    if (mem_wr) ram[mem_addr[7:0]] <= mem_wdata;
  end
  assign mem_rdata  = mem_rd ? ram[mem_addr[7:0]] : junk;
  assign code_rdata = code_rd ? code_addr[7:0] ^ code_addr[15:8] ^ 8'h5A : ~junk;
endmodule : bca_mem_model
`default_nettype wire

// File: verif/bca_core_tb.sv
`default_nettype none
module bca_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bca_pkg::*;
  logic        clk, arst_n, instr_valid, instr_ready, instr_done, instr_error;
  bca_op_e     instr_op;
  bca_mode_e   instr_mode;
  logic [2:0]  instr_reg;
  logic [1:0]  bank_sel;
  logic [7:0]  instr_addr, instr_imm, acc, mul_operand, mem_wdata, mem_rdata, code_rdata;
  logic [15:0] mem_addr, code_addr, wide_data_pointer;
  logic        mem_wide, mem_rd, mem_wr, code_rd, carry, aux_carry, overflow;
  int          failures, checked, ma, mb, mdp, mcy, mac, mov, bk;
  int          wr [32];
  int          bm [256];

  bca_core i_bca_core (.*);
  bca_mem_model i_bca_mem_model (.*);

  always #2.5 clk = ~clk;

  task automatic cmp(input logic [15:0] got, input int exp);
    checked++;
    if (got !== 16'(exp)) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, 16'(exp));
    end
  endtask : cmp

  task automatic end_sim;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  function automatic int cyc(bca_op_e o, bca_mode_e m);
    case (o)
      add_op, add_with_carry_op, subtract_with_borrow_op, logical_and_op, logical_or_op,
      logical_xor_op, load_acc_op: begin
        if (m == mode_reg) return 1;
        if (m inside {mode_direct, mode_indirect, mode_immediate}) return 2;
        if (o inside {[logical_and_op:logical_xor_op]}
            && m inside {mode_direct_acc, mode_direct_imm}) return 3;
        if (o == load_acc_op && m == mode_indirect_wide) return 3;
      end
      increment_op, decrement_op:
        return m == mode_acc ? 1 : m == mode_reg ? 2 : m inside {mode_direct, mode_indirect} ? 3 : 0;
      multiply_op, load_mul_operand_op, bit_to_carry_op: return 2;
      divide_op: return 6;
      code_read_op: return 5;
      load_pointer_op, decimal_adjust_op: return 3;
      default: return 1;
    endcase
    return 0;
  endfunction : cyc

  // model first, then drive and watch
  task automatic run(input bca_op_e op, input bca_mode_e md, input int rg, ad, im);
    int n, nr, ne, s, ea, ill, rd, wv, t, k, x, y, c;
    k = bk * 8 + rg;
    ne = cyc(op, md);
    ill = ne == 0;
    {rd, wv, ea, s, nr, n} = {32'd0, -32'sd1, ad, im, 32'd0, 32'd0};
    if (!ill) begin
      case (md)
        mode_reg: s = wr[k];
        mode_direct, mode_direct_acc, mode_direct_imm: rd = 1;
        mode_indirect: {ea, rd} = {wr[bk * 8 + rg % 2], 32'd1};
        mode_indirect_wide: {ea, rd} = {mdp, 32'd1};
        default: ;
      endcase
      if (rd) s = bm[ea % 256];
      c = op inside {add_with_carry_op, subtract_with_borrow_op} ? mcy : 0;
      x = md inside {mode_direct_acc, mode_direct_imm} ? s : ma;
      y = md == mode_direct_imm ? im : md == mode_direct_acc ? ma : s;
      case (op)
        add_op, add_with_carry_op: begin
          t = ma + s + c;
          mac = ma % 16 + s % 16 + c > 15;
          mov = (~(ma ^ s) & (ma ^ t) & 128) != 0;
          {mcy, ma} = {32'(t > 255), t & 255};
        end
        subtract_with_borrow_op: begin
          t = ma - s - c;
          mac = ma % 16 < s % 16 + c;
          mov = ((ma ^ s) & (ma ^ t) & 128) != 0;
          {mcy, ma} = {32'(t < 0), t & 255};
        end
        logical_and_op, logical_or_op, logical_xor_op: begin
          t = op == logical_and_op ? x & y : op == logical_or_op ? x | y : x ^ y;
          if (md inside {mode_direct_acc, mode_direct_imm}) wv = t;
          else ma = t;
        end
        increment_op, decrement_op: begin
          t = ((md == mode_acc ? ma : s) + (op == increment_op ? 1 : 255)) & 255;
          if (md == mode_acc) ma = t;
          else if (md == mode_reg) wr[k] = t;
          else wv = t;
        end
        inc_pointer_op: mdp = (mdp + 1) & 16'hFFFF;
        multiply_op: begin
          t = ma * mb;
          {ma, mb, mcy, mov} = {t & 255, t >> 8, 32'd0, 32'(t > 255)};
        end
        divide_op: begin
          {mcy, mov} = {32'd0, 32'(mb == 0)};
          if (mb != 0) {ma, mb} = {ma / mb, ma % mb};
        end
        rotate_left_op: ma = (ma * 2 | ma >> 7) & 255;
        rotate_right_op: ma = ma >> 1 | (ma & 1) * 128;
        rotate_left_carry_op: {mcy, ma} = {ma >> 7, (ma * 2 | mcy) & 255};
        rotate_right_carry_op: {mcy, ma} = {ma & 1, ma >> 1 | mcy * 128};
        swap_nibbles_op: ma = ma % 16 * 16 + ma / 16;
        decimal_adjust_op: begin
          t = ma + (ma % 16 > 9 || mac ? 6 : 0);
          t += t / 16 > 9 || mcy ? 96 : 0;
          {mcy, ma} = {32'(mcy | t > 255), t & 255};
        end
        bit_to_carry_op: begin
          {ea, rd} = {ad < 128 ? 32 + ad / 8 : ad & 248, 32'd1};
          mcy = bm[ea] >> ad % 8 & 1;
        end
        clear_acc_op: ma = 0;
        complement_acc_op: ma = ma ^ 255;
        code_read_op: begin
          {ea, rd} = {(mdp + ma) & 16'hFFFF, 32'd1};
          ma = (ea ^ ea >> 8 ^ 8'h5A) & 255;
        end
        load_acc_op: ma = s;
        store_reg_op: wr[k] = ma;
        load_mul_operand_op: mb = ma;
        load_pointer_op: mdp = ad * 256 + im;
        default: ;
      endcase
      if (wv >= 0) bm[ea % 256] = wv;
    end
    if (ill) ne = 1;
    {instr_op, instr_mode, instr_reg, instr_addr, instr_imm} = {op, md, 3'(rg), 8'(ad), 8'(im)};
    bank_sel = 2'(bk);
    instr_valid = 1'b1;
    @(posedge clk);
    do begin
      @(negedge clk);
      n++;
      if (n == 1 && ne > 1) instr_valid = 1'b0;
      if (mem_rd) cmp(mem_wide, md == mode_indirect_wide);
      if (mem_rd | code_rd) begin
        nr++;
        cmp(code_rd ? code_addr : mem_addr, ea);
      end
      if (mem_wr) cmp(mem_wdata, wv);
    end while (!(instr_done | instr_error) && n < 12);
    cmp(n, ne);
    cmp(instr_error, ill);
    cmp(nr, rd);
    cmp({acc, mul_operand}, ma * 256 + mb);
    cmp(wide_data_pointer, mdp);
    cmp({carry, aux_carry, overflow}, mcy * 4 + mac * 2 + mov);
  endtask : run

  initial begin
    bca_op_e   op;
    bca_mode_e md;
    {clk, arst_n, instr_valid, instr_reg, instr_addr, instr_imm, bank_sel} = '0;
    {instr_op, instr_mode} = {add_op, mode_acc};
    {failures, checked, ma, mb, mdp, mcy, mac, mov} = '0;
    for (int i = 0; i < 256; i++) bm[i] = (i * 37 + 11) & 255;
    for (int i = 0; i < 32; i++) wr[i] = 0;
    void'($urandom(32'h024bc778));
    repeat (2) @(negedge clk);
    cmp(instr_ready, 1);
    cmp({acc, mul_operand}, 0);
    cmp({wide_data_pointer, carry, aux_carry, overflow, instr_done}, 0);
    arst_n = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 1500; i++) begin
      op = bca_op_e'($urandom_range(0, 24));
      md = bca_mode_e'($urandom_range(0, 7));
      if (!(op inside {[add_op:decrement_op], [logical_and_op:logical_xor_op], load_acc_op}))
        md = mode_acc;
      bk = $urandom_range(0, 3);
      run(op, md, $urandom_range(0, 7), $urandom_range(0, 255), $urandom_range(0, 255));
      if ($urandom_range(0, 3) == 0) begin
        instr_valid = 1'b0;
        @(negedge clk);
      end
    end
    instr_valid = 1'b0;
    $display("test random done");
    end_sim();
  end

  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule : bca_core_tb
`default_nettype wire
